// ### src/watchdog_enable_ctrl_regs.v
`include "wd_regs_defines.vh"

// Functional notes
// - Address 34 is decoded from the command byte; two data bytes follow.
// - Bit 0 of register 34 enables the watchdog when one, disables at zero.
// - Register 34 resets to watchdog enabled, bits 15 to 1 zero.
// - Watchdog enable changes only while CAN flash mode is active.
// - Address 35 is decoded from the command byte; two data bytes follow.
// - Register 35 resets with only bits 5, 4, 2 and 1 set.
module watchdog_enable_ctrl_regs (
    // Clock, reset and clock enable.
    input wire i_clock,
    input wire i_rst,
    input wire i_clk_en,
    // Byte stream from the serial framing logic.
    input wire i_frame_start,
    input wire i_byte_valid,
    input wire [7:0] i_byte,
    input wire i_frame_end,
    // Flash mode level from the transmit pin comparator.
    input wire i_flash_mode,
    // Read data toward the serial shifter.
    output reg [7:0] o_read_byte,
    output wire o_addr_hit,
    // Register contents for the rest of the device.
    output wire o_watchdog_enable,
    output wire [15:0] o_factory_settings,
    // Event pulses.
    output reg o_write_done,
    output reg o_write_refused
);

    // Sequencer state codes.
    localparam ST_IDLE = 2'h0;
    localparam ST_DATA_HI = 2'h1;
    localparam ST_DATA_LO = 2'h2;
    localparam ST_DONE = 2'h3;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [1:0] op_reg;
    reg [5:0] addr_reg;
    reg watchdog_enable_bit_reg;
    reg [6:0] factory_reg;
    wire flash_mode_sync;
    wire is_write;
    wire hit_wd;
    wire hit_factory;
    wire [15:0] wd_reg_value;
    wire [15:0] factory_reg_value;
    wire [15:0] cmd_read_word;
    wire [15:0] addr_read_word;
    wire byte_taken;
    wire commit;
    wire apply_wd;
    wire apply_factory;
    wire refuse_wd;

    // Returns the register word at an address, zero for other addresses.
    // Reads of unused addresses stay harmless: the host just sees zero.
    function [15:0] reg_value;
        input [5:0] addr;
        input [15:0] wd_value;
        input [15:0] fac_value;
        begin
            if (addr == `ADDR_WD_ENABLE_CTRL) begin
                reg_value = wd_value;
            end else if (addr == `ADDR_SW_FACTORY) begin
                reg_value = fac_value;
            end else begin
                reg_value = `REG_ZERO;
            end
        end
    endfunction

    // The flash level comes from a pin, so it is synchronised first.
    // The two stages delay the level by two cycles before it counts.
    flash_level_sync u_flash_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_level(i_flash_mode),
        .o_level(flash_mode_sync)
    );

    // Reserved bits are not stored and always read back as zero, so a
    // host that writes them anyway cannot make them stick.
    assign wd_reg_value = {`WD_PAD_ZERO, watchdog_enable_bit_reg};
    assign factory_reg_value = {`FACTORY_PAD_ZERO, factory_reg};

    // Command decode from the captured command byte.
    assign is_write = (op_reg == `OP_WRITE);
    assign hit_wd = (addr_reg == `ADDR_WD_ENABLE_CTRL);
    assign hit_factory = (addr_reg == `ADDR_SW_FACTORY);

    // Register contents and address match toward the rest of the device.
    assign o_addr_hit = hit_wd | hit_factory;
    assign o_watchdog_enable = watchdog_enable_bit_reg;
    assign o_factory_settings = factory_reg_value;

    // A byte that shares its cycle with a frame start is dropped, because
    // the start marker means the host has abandoned the frame before it.
    assign byte_taken = i_byte_valid && !i_frame_start;

    // A write takes effect when the second data byte arrives, never on the
    // frame end, so a short frame commits nothing.
    assign commit = byte_taken && (state_reg == ST_DATA_LO) && is_write;

    // Outcome of a committed write. Only the watchdog enable bit is guarded
    // by flash mode; a refused write is still reported as an event.
    assign apply_wd = commit && hit_wd && flash_mode_sync;
    assign apply_factory = commit && hit_factory;
    assign refuse_wd = commit && hit_wd && !flash_mode_sync;

    // Read words: the command byte itself selects the high byte, and the
    // captured address selects the low byte one byte later.
    assign cmd_read_word = reg_value(i_byte[`CMD_ADDR_HI:`CMD_ADDR_LO],
        wd_reg_value, factory_reg_value);
    assign addr_read_word = reg_value(addr_reg, wd_reg_value,
        factory_reg_value);

    // Frame sequencer: command byte, high data byte, low data byte.
    // The done state swallows extra bytes until a delimiter arrives.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (i_byte_valid) begin
                    state_next = ST_DATA_HI;
                end
            end
            ST_DATA_HI: begin
                if (i_byte_valid) begin
                    state_next = ST_DATA_LO;
                end
            end
            ST_DATA_LO: begin
                if (i_byte_valid) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_DONE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Frame delimiters override the byte count in either direction.
        if (i_frame_start || i_frame_end) begin
            state_next = ST_IDLE;
        end
    end

    // Sequencer state and command capture. The high data byte is not kept,
    // since no stored field lives in it.
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            op_reg <= `OP_READ;
            addr_reg <= `ADDR_ZERO;
        end else if (i_clk_en) begin
            state_reg <= state_next;
            if (byte_taken && (state_reg == ST_IDLE)) begin
                op_reg <= i_byte[`CMD_OP_HI:`CMD_OP_LO];
                addr_reg <= i_byte[`CMD_ADDR_HI:`CMD_ADDR_LO];
            end
        end
    end

    // Read data: high byte after the command, low byte after the first
    // data byte, so the shifter always holds the next byte to send out.
    // A frame start clears it, so old data never leaks into a new frame.
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_read_byte <= `BYTE_ZERO;
        end else if (i_clk_en) begin
            if (i_frame_start) begin
                o_read_byte <= `BYTE_ZERO;
            end else if (byte_taken && (state_reg == ST_IDLE)) begin
                o_read_byte <= cmd_read_word[`HI_BYTE_HI:`HI_BYTE_LO];
            end else if (byte_taken && (state_reg == ST_DATA_HI)) begin
                o_read_byte <= addr_read_word[`LO_BYTE_HI:`LO_BYTE_LO];
            end
        end
    end

    // Watchdog enable bit. Outside flash mode the write is dropped but the
    // frame still runs to its end, so the host sees no protocol fault.
    // Flash mode is taken only from the synchronised level.
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            watchdog_enable_bit_reg <= `WATCHDOG_ENABLE_BIT_RESET;
        end else if (i_clk_en) begin
            if (apply_wd) begin
                watchdog_enable_bit_reg <= i_byte[`WATCHDOG_ENABLE_BIT_BIT];
            end
        end
    end

    // Factory settings. The host is expected never to change them; the
    // cells stay writable so a test floor can still trim them.
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            factory_reg <= `FACTORY_RESET;
        end else if (i_clk_en) begin
            if (apply_factory) begin
                factory_reg <= i_byte[`FACTORY_HI:`FACTORY_LO];
            end
        end
    end

    // One-cycle pulses reporting the outcome of each write to a register.
    // They rise one cycle after the low data byte, with the new contents.
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_write_done <= `BIT_ZERO;
            o_write_refused <= `BIT_ZERO;
        end else if (i_clk_en) begin
            o_write_done <= apply_wd || apply_factory;
            o_write_refused <= refuse_wd;
        end
    end

endmodule

// ### src/wd_regs_defines.vh
`ifndef WD_REGS_DEFINES_VH
`define WD_REGS_DEFINES_VH

// Command byte layout: access bits on top, register address below.
`define CMD_OP_HI 7
`define CMD_OP_LO 6
`define CMD_ADDR_HI 5
`define CMD_ADDR_LO 0
`define CMD_ADDR_W 6

// Access codes carried in the two top bits of the command byte.
`define OP_WRITE 2'h0
`define OP_READ 2'h1
`define OP_READ_CLEAR 2'h2
`define OP_READ_INFO 2'h3

// Register addresses (decimal 34 and 35).
`define ADDR_WD_ENABLE_CTRL 6'h22
`define ADDR_SW_FACTORY 6'h23

// Register width, byte slices and field positions.
`define REG_W 16
`define BYTE_W 8
`define HI_BYTE_HI 15
`define HI_BYTE_LO 8
`define LO_BYTE_HI 7
`define LO_BYTE_LO 0
`define WATCHDOG_ENABLE_BIT_BIT 0
`define FACTORY_HI 6
`define FACTORY_LO 0
`define FACTORY_W 7

// Reset values.
`define WATCHDOG_ENABLE_BIT_RESET 1'h1
`define FACTORY_RESET 7'h36
`define REG_ZERO 16'h0000
`define BYTE_ZERO 8'h00
`define BIT_ZERO 1'h0
`define ADDR_ZERO 6'h00
`define WD_PAD_ZERO 15'h0000
`define FACTORY_PAD_ZERO 9'h000

`endif

// ### src/flash_level_sync.v
`include "wd_regs_defines.vh"

// Two-stage synchroniser for a level that arrives from a pin.
module flash_level_sync (
    // Clock, reset and enable.
    input wire i_clock,
    input wire i_rst,
    input wire i_clk_en,
    // Asynchronous level in, synchronised level out.
    input wire i_level,
    output wire o_level
);

    reg meta_reg;
    reg sync_reg;

    // The first stage feeds only the second stage, to contain metastability.
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= `BIT_ZERO;
            sync_reg <= `BIT_ZERO;
        end else if (i_clk_en) begin
            meta_reg <= i_level;
            sync_reg <= meta_reg;
        end
    end

    assign o_level = sync_reg;

endmodule

// ### dv/wd_regs_monitor.sv
module wd_regs_monitor (
    input wire i_clock,
    input wire i_rst,
    input wire i_byte_valid,
    input wire i_flash_mode,
    input wire o_watchdog_enable,
    input wire [15:0] o_factory_settings,
    input wire o_write_done,
    input wire o_write_refused
);
    timeunit 1ns;
    timeprecision 100ps;
    // All checks share the one clock and are quiet while reset is held.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    a_reset_values: assert property (
        $fell(i_rst) |-> o_watchdog_enable && o_factory_settings == 16'h0036)
        else $error("reset values wrong");
    a_reserved_zero: assert property (o_factory_settings[15:7] == 9'h000)
        else $error("reserved bits set");
    a_flash_hold: assert property (
        !i_flash_mode [*3] |=> $stable(o_watchdog_enable))
        else $error("enable moved outside flash mode");
    a_change_cause: assert property (
        !$stable(o_watchdog_enable) |-> o_write_done)
        else $error("enable moved without a write");
    a_refuse_hold: assert property (
        o_write_refused |-> $stable(o_watchdog_enable))
        else $error("refused write changed enable");
    a_done_cause: assert property (
        o_write_done || o_write_refused |-> $past(i_byte_valid))
        else $error("write pulse without a byte");
    a_one_outcome: assert property (o_write_done |-> !o_write_refused)
        else $error("done and refused together");
    a_pulse_single: assert property (o_write_done |=> !o_write_done)
        else $error("done pulse too long");
endmodule

bind watchdog_enable_ctrl_regs wd_regs_monitor u_wd_regs_monitor (
    .i_clock(i_clock), .i_rst(i_rst), .i_byte_valid(i_byte_valid),
    .i_flash_mode(i_flash_mode), .o_watchdog_enable(o_watchdog_enable),
    .o_factory_settings(o_factory_settings), .o_write_done(o_write_done),
    .o_write_refused(o_write_refused));

// ### dv/wd_regs_host.sv
module wd_regs_host (
    input wire i_clock,
    input wire [7:0] i_read_byte,
    output reg o_frame_start,
    output reg o_byte_valid,
    output reg [7:0] o_byte,
    output reg o_frame_end,
    output reg o_seen,
    output reg [15:0] o_rd
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {o_frame_start, o_byte_valid, o_byte, o_frame_end, o_seen} = 0;
    initial o_rd = 16'h0000;
    // One whole frame; the bench hands reserved bits only as zero.
    task frame(input [7:0] cmd, input [15:0] data);
        @(posedge i_clock) #1 o_frame_start = 1;
        @(posedge i_clock) #1 o_frame_start = 0;
        o_byte_valid = 1;
        o_byte = cmd;
        @(posedge i_clock) #1 o_byte = data[15:8];
        o_rd[15:8] = i_read_byte;
        @(posedge i_clock) #1 o_byte = data[7:0];
        o_rd[7:0] = i_read_byte;
        @(posedge i_clock) #1 o_byte_valid = 0;
        o_byte = ~data[7:0]; // A released data line must not look valid.
        o_frame_end = 1;
        o_seen = 1;
        @(posedge i_clock) #1 o_frame_end = 0;
        o_seen = 0;
    endtask
endmodule

// ### dv/watchdog_enable_ctrl_regs_bench.sv
module watchdog_enable_ctrl_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    reg i_clock = 0, i_rst = 1, i_flash_mode = 0, wd_exp = 1, clk_en = 1;
    wire fs, bv, fe, seen, wd, wdone, wref, hit;
    wire [7:0] b, rb;
    wire [15:0] rd, fac;
    integer miscompares = 0, comparisons = 0, cycles = 0, seed = 16391, i;
    reg [35:0] q[$];
    reg [35:0] note;
    wire [35:0] got = {rd, wd, fac, wdone, wref, hit};
    always #12.5 i_clock = ~i_clock;
    watchdog_enable_ctrl_regs u_watchdog_enable_ctrl_regs (.i_clock(i_clock),
        .i_rst(i_rst), .i_clk_en(clk_en), .i_frame_start(fs), .i_byte_valid(bv),
        .i_byte(b), .i_frame_end(fe), .i_flash_mode(i_flash_mode),
        .o_read_byte(rb), .o_addr_hit(hit), .o_watchdog_enable(wd),
        .o_factory_settings(fac), .o_write_done(wdone), .o_write_refused(wref));
    wd_regs_host u_wd_regs_host (.i_clock(i_clock), .i_read_byte(rb),
        .o_frame_start(fs), .o_byte_valid(bv), .o_byte(b), .o_frame_end(fe),
        .o_seen(seen), .o_rd(rd));
    task close_out;
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Note the expected frame outcome, then let the host run it.
    task xfer(input [7:0] c, input [15:0] d, r, input w, dn, rf);
        q.push_back({r, w, 16'h0036, dn, rf,
            (c[5:0] == 6'h22) || (c[5:0] == 6'h23)});
        wd_exp = w;
        u_wd_regs_host.frame(c, d);
    endtask
    task wr34(input v);
        if (i_flash_mode) xfer(8'h22, {15'h0, v}, {15'h0, wd_exp}, v, 1, 0);
        else xfer(8'h22, {15'h0, v}, {15'h0, wd_exp}, wd_exp, 0, 1);
    endtask
    // Each finished frame retires the oldest note; a hang ends the run.
    always @(posedge i_clock) begin
        cycles = cycles + 1;
        if (cycles == 1000) begin
            miscompares = miscompares + 1;
            close_out;
        end
        if (seen) begin
            note = q.pop_front();
            comparisons = comparisons + 1;
            if (note !== got) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: frame %h", $time, note);
            end
        end
    end
    // Reads under the three read access codes 1 to 3, refusals, flash writes, a second reset.
    initial begin
        repeat (8) @(posedge i_clock);
        #1 i_rst = 0;
        for (i = 1; i < 4; i = i + 1) begin
            xfer({i[1:0], 6'h22}, 16'h0000, 16'h0001, 1, 0, 0);
            xfer({i[1:0], 6'h23}, 16'h0000, 16'h0036, 1, 0, 0);
        end
        xfer(8'h64, 16'h0000, 16'h0000, 1, 0, 0);
        xfer(8'h24, 16'h0001, 16'h0000, 1, 0, 0);
        wr34(0);
        i_flash_mode = 1;
        repeat (3) @(posedge i_clock);
        for (i = 0; i < 6; i = i + 1) wr34($random(seed));
        xfer(8'h23, 16'h0036, 16'h0036, wd_exp, 1, 0);
        // A frozen clock enable must swallow a whole flash-mode write.
        clk_en = 0;
        xfer(8'h22, {15'h0, !wd_exp}, 16'h3636, wd_exp, 0, 0);
        clk_en = 1;
        i_flash_mode = 0;
        repeat (3) @(posedge i_clock);
        #1 wr34(!wd_exp);
        i_rst = 1;
        @(posedge i_clock) #1 i_rst = 0;
        xfer(8'h62, 16'h0000, 16'h0001, 1, 0, 0);
        repeat (3) @(posedge i_clock);
        close_out;
    end
endmodule
